// ==== verilog/protect_consts.svh ====
// constants for the sector/block write protection block
// assumes inclusion by bare name from package and modules
`ifndef PROTECT_CONSTS_SVH
`define PROTECT_CONSTS_SVH
`define GROUP_COUNT 542
`define GROUP_BITS 10
`define BIG_BLOCKS 510
`define SMALL_SECTORS 32
`define BLOCK_SHIFT 16
`define SECTOR_SHIFT 12
`define ADDR_BITS 25
`define TOP_SMALL_BASE 9'h1FE
`define PROG_TIME_US 400
`define ERASE_TIME_US 45000
`define CLOCK_MHZ 25
`define BIT_ERASED 1'h1
`define BIT_PROTECTED 1'h0
`endif

// ==== verilog/protect_pkg.sv ====
// types for the sector/block write protection block
// assumes protect_consts.svh is on the include path
`include "protect_consts.svh"
package protect_pkg;
    typedef struct packed {
        logic valid;
        logic [`ADDR_BITS-1:0] addr;
    } array_req_t;
    typedef struct packed {
        logic dyb_write;
        logic dyb_value;
        logic ppb_program;
        logic ppb_erase;
        logic ppb_read;
        logic lock_clear;
        logic unlock_ok;
        logic soft_reset;
        logic [`ADDR_BITS-1:0] addr;
    } prot_cmd_t;
    typedef enum logic [1:0] {ST_IDLE, ST_PROGRAM, ST_ERASE} nv_state_t;
endpackage

// ==== verilog/persist_bit_mem.sv ====
// non-volatile persistent bit store, one bit per protection group
// assumes its contents survive reset: no reset on the array
`timescale 1ns/1ns
`include "protect_consts.svh"
module persist_bit_mem #(
    parameter int DEPTH = `GROUP_COUNT,
    parameter int AW = `GROUP_BITS
) (
    input wire logic clk,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic rd_data,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic erase_all
);
    // ****************************************
    // storage
    // ****************************************
    logic [DEPTH-1:0] cell_reg = {DEPTH{`BIT_ERASED}};

    always_ff @(posedge clk) begin
        if (erase_all) begin
            cell_reg <= {DEPTH{`BIT_ERASED}};
        end else if (wr_en && (wr_addr < AW'(DEPTH))) begin
            cell_reg[wr_addr] <= `BIT_PROTECTED;
        end
    end

    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= (rd_addr < AW'(DEPTH)) ? cell_reg[rd_addr] : `BIT_ERASED;
        end
    end
endmodule

// ==== verilog/sector_block_write_protect.sv ====
// sector/block write protection: persistent, dynamic and lock bits
// assumes commands decoded upstream as one-cycle pulses on CLOCK
//
// Function
// - group unprotected only when persistent and dynamic bits are both one.
// - top option: blocks 0..509 one group each, top two blocks per 4KB sector.
// - persistent bits programmed singly to zero; erase sets all to one together.
// - no single-bit erase; bulk erase ignores the supplied address.
// - program takes page time, erase sector time; busy stays visible.
// - array reads refused while a persistent bit is programmed.
// - delivered state has every persistent bit erased to one.
// - dynamic bit write sets zero or one any number of times, lock ignored.
// - any reset returns every dynamic bit to unprotected.
// - persistent bits survive power cycles and resets.
// - lock zero makes persistent program and erase fail, bits unchanged.
// - persistent mode: reset sets lock; once cleared stays cleared.
// - password mode: reset clears lock; only password unlock sets it.
// - lock-write command clears lock; software reset leaves lock alone.
// - mode chosen by one-time-programmable bits, fixed once programmed; the block samples PASSWORD_MODE every cycle.
// - bottom option puts the 32 small sectors in the lowest two blocks.
`timescale 1ns/1ns
`include "protect_consts.svh"
module sector_block_write_protect #(
    parameter int PROG_CYCLES = (`PROG_TIME_US * `CLOCK_MHZ),
    parameter int ERASE_CYCLES = (`ERASE_TIME_US * `CLOCK_MHZ)
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic HW_RESET_N,
    input wire logic PASSWORD_MODE,
    input wire logic SMALL_SECTOR_PLACEMENT,
    input wire protect_pkg::prot_cmd_t CMD,
    input wire protect_pkg::array_req_t ARRAY_READ,
    input wire protect_pkg::array_req_t ARRAY_WRITE,
    output logic ARRAY_READ_OK,
    output logic ARRAY_WRITE_OK,
    output logic ARRAY_WRITE_REJECT,
    output logic BUSY,
    output logic PPB_FAIL,
    output logic PPB_READ_VALID,
    output logic PPB_READ_DATA,
    output logic PERSIST_CHANGE_LOCK
);
    import protect_pkg::*;

    // ****************************************
    // address to protection group
    // ****************************************
    function automatic logic [`GROUP_BITS-1:0] group_of(input logic [`ADDR_BITS-1:0] a,
                                                      input logic bottom);
        logic [8:0] blk;
        logic [4:0] sec;
        blk = a[`ADDR_BITS-1:`BLOCK_SHIFT];
        sec = a[`BLOCK_SHIFT:`SECTOR_SHIFT];
        if (bottom) begin
            // small sectors take groups 0..31, blocks 2..511 follow
            if (blk < 9'h002) begin
                group_of = {5'h00, sec};
            end else begin
                group_of = `GROUP_BITS'(blk) + `GROUP_BITS'(`SMALL_SECTORS - 2);
            end
        end else begin
            if (blk >= `TOP_SMALL_BASE) begin
                group_of = `GROUP_BITS'(`BIG_BLOCKS) + `GROUP_BITS'(sec);
            end else begin
                group_of = `GROUP_BITS'(blk);
            end
        end
    endfunction

    // ****************************************
    // mode capture and lock bit
    // ****************************************
    // mode straps are one-time bits; they are sampled every cycle but never change
    logic password_mode_reg;
    logic lock_reg;
    logic hw_reset_seen_reg;
    wire hard_reset = !HW_RESET_N;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            password_mode_reg <= 1'h0;
        end else begin
            password_mode_reg <= PASSWORD_MODE;
        end
    end

    // starts high so the first cycle after power-up loads the lock like a hard reset
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            hw_reset_seen_reg <= 1'h1;
        end else begin
            hw_reset_seen_reg <= hard_reset;
        end
    end

    // lock loads its mode-dependent value on the first cycle after any hard reset
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            lock_reg <= 1'h0;
        end else if (hw_reset_seen_reg || hard_reset) begin
            lock_reg <= !PASSWORD_MODE;
        end else if (CMD.lock_clear) begin
            lock_reg <= 1'h0;
        end else if (CMD.unlock_ok && password_mode_reg) begin
            lock_reg <= 1'h1;
        end
    end
    // soft_reset deliberately not used above

    // ****************************************
    // dynamic bits
    // ****************************************
    logic [`GROUP_COUNT-1:0] dyb_reg;
    wire [`GROUP_BITS-1:0] cmd_group = group_of(CMD.addr, SMALL_SECTOR_PLACEMENT);

    genvar gi;
    generate
        for (gi = 0; gi < `GROUP_COUNT; gi++) begin : g_dyb
            wire hit = CMD.dyb_write && (cmd_group == `GROUP_BITS'(gi));
            always_ff @(posedge CLOCK or negedge RST_N) begin
                if (!RST_N) begin
                    dyb_reg[gi] <= `BIT_ERASED;
                end else if (hard_reset || CMD.soft_reset) begin
                    dyb_reg[gi] <= `BIT_ERASED;
                end else if (hit) begin
                    dyb_reg[gi] <= CMD.dyb_value;
                end
            end
        end
    endgenerate

    // ****************************************
    // persistent bit sequencer
    // ****************************************
    nv_state_t state_reg;
    nv_state_t state_next;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic [`GROUP_BITS-1:0] target_reg;
    logic fail_reg;
    logic fail_next;

    wire idle = (state_reg == ST_IDLE);
    wire start_prog = idle && CMD.ppb_program && lock_reg;
    wire start_erase = idle && CMD.ppb_erase && lock_reg;
    wire refused = idle && (CMD.ppb_program || CMD.ppb_erase) && !lock_reg;
    wire done = !idle && (count_reg == 32'h0000_0000);
    wire mem_write = done && (state_reg == ST_PROGRAM);
    wire mem_erase = done && (state_reg == ST_ERASE);

    // program, erase and persistent read commands arriving while busy are dropped: no queue, the host must poll busy
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_prog) begin
                    state_next = ST_PROGRAM;
                    count_next = 32'(PROG_CYCLES - 1);
                end else if (start_erase) begin
                    state_next = ST_ERASE;
                    count_next = 32'(ERASE_CYCLES - 1);
                end
            end
            ST_PROGRAM, ST_ERASE: begin
                if (done) begin
                    state_next = ST_IDLE;
                end else begin
                    count_next = count_reg - 32'h0000_0001;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // failure flag stands until the next accepted start
    assign fail_next = (start_prog || start_erase) ? 1'h0 : (refused ? 1'h1 : fail_reg);

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
            count_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            target_reg <= '0;
        end else if (start_prog) begin
            target_reg <= cmd_group;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            fail_reg <= 1'h0;
        end else begin
            fail_reg <= fail_next;
        end
    end

    // ****************************************
    // persistent bit store and read
    // ****************************************
    logic ppb_rd;
    logic ppb_rd_valid_reg;
    wire [`GROUP_BITS-1:0] read_group = group_of(CMD.addr, SMALL_SECTOR_PLACEMENT);
    wire ppb_rd_req = CMD.ppb_read && idle;

    persist_bit_mem #(
        .DEPTH(`GROUP_COUNT),
        .AW(`GROUP_BITS)
    ) u_mem (
        .clk(CLOCK),
        .rd_en(ppb_rd_req),
        .rd_addr(read_group),
        .rd_data(ppb_rd),
        .wr_en(mem_write),
        .wr_addr(target_reg),
        .erase_all(mem_erase)
    );

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ppb_rd_valid_reg <= 1'h0;
        end else begin
            ppb_rd_valid_reg <= ppb_rd_req;
        end
    end

    // ****************************************
    // array gating
    // ****************************************
    // the persistent bit of a write target is looked up combinationally; the store reads through a register,
    // so the array path keeps a shadow copy of the store in 542 flops
    logic [`GROUP_COUNT-1:0] ppb_shadow_reg = {`GROUP_COUNT{`BIT_ERASED}};
    always_ff @(posedge CLOCK) begin
        if (mem_erase) begin
            ppb_shadow_reg <= {`GROUP_COUNT{`BIT_ERASED}};
        end else if (mem_write) begin
            ppb_shadow_reg[target_reg] <= `BIT_PROTECTED;
        end
    end

    wire [`GROUP_BITS-1:0] wr_group = group_of(ARRAY_WRITE.addr, SMALL_SECTOR_PLACEMENT);
    wire wr_open = ppb_shadow_reg[wr_group] && dyb_reg[wr_group];
    wire wr_ok = ARRAY_WRITE.valid && idle && wr_open;
    wire wr_reject = ARRAY_WRITE.valid && !(idle && wr_open);
    wire rd_ok = ARRAY_READ.valid && (state_reg != ST_PROGRAM);

    logic rd_ok_reg;
    logic wr_ok_reg;
    logic wr_reject_reg;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rd_ok_reg <= 1'h0;
        end else begin
            rd_ok_reg <= rd_ok;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wr_ok_reg <= 1'h0;
        end else begin
            wr_ok_reg <= wr_ok;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wr_reject_reg <= 1'h0;
        end else begin
            wr_reject_reg <= wr_reject;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // read data is forced low outside its valid cycle so a stale bit never shows
    assign ARRAY_READ_OK = rd_ok_reg;
    assign ARRAY_WRITE_OK = wr_ok_reg;
    assign ARRAY_WRITE_REJECT = wr_reject_reg;
    assign BUSY = !idle;
    assign PPB_FAIL = fail_reg;
    assign PPB_READ_VALID = ppb_rd_valid_reg;
    assign PPB_READ_DATA = ppb_rd_valid_reg & ppb_rd;
    assign PERSIST_CHANGE_LOCK = lock_reg;
endmodule

// ==== dv/sbwp_props.sv ====
// checker: port assertions for the protection block
// assumes a bind onto the top module and short program/erase counts
`timescale 1ns/1ns
module sbwp_props #(
    parameter int PROG_CYCLES = 5,
    parameter int ERASE_CYCLES = 8
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic HW_RESET_N,
    input wire logic PASSWORD_MODE,
    input wire protect_pkg::prot_cmd_t CMD,
    input wire protect_pkg::array_req_t ARRAY_READ,
    input wire protect_pkg::array_req_t ARRAY_WRITE,
    input wire logic ARRAY_READ_OK,
    input wire logic ARRAY_WRITE_OK,
    input wire logic ARRAY_WRITE_REJECT,
    input wire logic BUSY,
    input wire logic PPB_FAIL,
    input wire logic PPB_READ_VALID,
    input wire logic PERSIST_CHANGE_LOCK
);
    import protect_pkg::*;
    logic [15:0] busy_cnt_reg;
    logic start;
    assign start = (CMD.ppb_program || CMD.ppb_erase) && !BUSY;
    // busy length is counted, far too long for a repetition
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            busy_cnt_reg <= 16'h0000;
        end else begin
            busy_cnt_reg <= BUSY ? busy_cnt_reg + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // ********************
    // properties
    // ********************
    a_locked_start: assert property (
        start && !PERSIST_CHANGE_LOCK |=> !BUSY && PPB_FAIL) else $error("locked start ran");
    a_start_busy: assert property (
        start && PERSIST_CHANGE_LOCK |=> BUSY && !PPB_FAIL) else $error("start not busy");
    a_busy_length: assert property (
        $fell(BUSY) |-> busy_cnt_reg == PROG_CYCLES || busy_cnt_reg == ERASE_CYCLES)
        else $error("busy length wrong");
    a_read_idle: assert property (
        ARRAY_READ.valid && !BUSY |=> ARRAY_READ_OK) else $error("idle read refused");
    a_write_answer: assert property (
        ARRAY_WRITE.valid |=> ARRAY_WRITE_OK ^ ARRAY_WRITE_REJECT) else $error("write answer");
    a_write_busy: assert property (
        ARRAY_WRITE.valid && BUSY |=> ARRAY_WRITE_REJECT) else $error("busy write taken");
    a_ppb_read: assert property (
        CMD.ppb_read && !BUSY |=> PPB_READ_VALID ##1 !PPB_READ_VALID) else $error("ppb read");
    a_lock_clear: assert property (
        CMD.lock_clear && HW_RESET_N && $past(HW_RESET_N) |=> !PERSIST_CHANGE_LOCK)
        else $error("lock not cleared");
    a_lock_rise: assert property (
        $rose(PERSIST_CHANGE_LOCK) |-> !$past(RST_N) || !$past(RST_N, 2) || !$past(HW_RESET_N)
        || !$past(HW_RESET_N, 2) || (PASSWORD_MODE && $past(CMD.unlock_ok)))
        else $error("lock set without cause");
    a_hw_reload: assert property (
        !HW_RESET_N ##1 (HW_RESET_N && !CMD.unlock_ok && !CMD.lock_clear) [*2]
        |-> PERSIST_CHANGE_LOCK == !PASSWORD_MODE) else $error("lock reload");
endmodule
bind sector_block_write_protect sbwp_props #(
    .PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
) props_u (.*);

// ==== dv/host_cmd_model.sv ====
// host side model: command and array request pulses
// assumes one clock shared with the protection block
`timescale 1ns/1ns
`include "protect_consts.svh"
module host_cmd_model (
    input wire logic clock,
    output protect_pkg::prot_cmd_t cmd,
    output protect_pkg::array_req_t rd_req,
    output protect_pkg::array_req_t wr_req
);
    import protect_pkg::*;
    initial begin
        cmd = '0;
        rd_req = '0;
        wr_req = '0;
    end
    // ********************
    // tasks
    // ********************
    // released address shows its inverse so a stale value never looks right
    task automatic send(input prot_cmd_t c);
        @(posedge clock);
        cmd <= c;
        @(posedge clock);
        cmd <= {8'h00, ~c.addr};
    endtask
    task automatic access(input logic wr, input logic [`ADDR_BITS-1:0] a);
        @(posedge clock);
        if (wr) wr_req <= {1'b1, a};
        else rd_req <= {1'b1, a};
        @(posedge clock);
        if (wr) wr_req <= {1'b0, ~a};
        else rd_req <= {1'b0, ~a};
    endtask
endmodule

// ==== dv/sector_block_write_protect_test.sv ====
// testbench: protection block against the host model
// assumes program and erase counts cut to 5 and 8 cycles
`timescale 1ns/1ns
module sector_block_write_protect_test;
    import protect_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic hw_reset_n = 1'b1;
    logic password_mode = 1'b0;
    logic placement = 1'b0;
    prot_cmd_t cmd;
    array_req_t rd_req, wr_req;
    logic read_ok, write_ok, write_reject, busy, ppb_fail, ppb_valid, ppb_data, lock;
    int failures = 0;
    int checked = 0;
    int seed = 32'hd0a1;
    logic [4:0] notes[$];
    wire [4:0] res = {read_ok, write_ok, write_reject, ppb_valid, ppb_data};
    always #20 clock = ~clock;
    sector_block_write_protect #(.PROG_CYCLES(5), .ERASE_CYCLES(8)) dut_u (
        .CLOCK(clock), .RST_N(rst_n), .HW_RESET_N(hw_reset_n), .PASSWORD_MODE(password_mode),
        .SMALL_SECTOR_PLACEMENT(placement), .CMD(cmd), .ARRAY_READ(rd_req),
        .ARRAY_WRITE(wr_req), .ARRAY_READ_OK(read_ok), .ARRAY_WRITE_OK(write_ok),
        .ARRAY_WRITE_REJECT(write_reject), .BUSY(busy), .PPB_FAIL(ppb_fail),
        .PPB_READ_VALID(ppb_valid), .PPB_READ_DATA(ppb_data), .PERSIST_CHANGE_LOCK(lock));
    host_cmd_model host_u (.clock(clock), .cmd(cmd), .rd_req(rd_req), .wr_req(wr_req));
    // ********************
    // helpers
    // ********************
    task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmdp(input logic [7:0] f, input logic [24:0] a);
        host_u.send({f, a});
    endtask
    task automatic wr(input logic [24:0] a, input logic ok);
        notes.push_back(ok ? 5'h08 : 5'h04);
        host_u.access(1'b1, a);
    endtask
    task automatic pread(input logic [24:0] a, input logic v);
        notes.push_back({4'h1, v});
        cmdp(8'h08, a);
    endtask
    task automatic wait_idle();
        @(posedge clock);
        for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clock);
        repeat (2) @(posedge clock);
    endtask
    task automatic hw_reset();
        @(posedge clock);
        hw_reset_n <= 1'b0;
        @(posedge clock);
        hw_reset_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask
    // each answer pulse takes the oldest note; a pulse with none pending is wrong
    always @(negedge clock) begin
        if (rst_n && res !== 5'h00) begin
            if (notes.size() == 0) check("answer", res, 5'h00);
            else check("answer", res, notes.pop_front());
        end
    end
    initial begin
        #(40 * 6000);
        failures++;
        report_and_stop();
    end
    // ********************
    // scenarios
    // ********************
    initial begin
        logic [24:0] a, b;
        int r;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(negedge clock);
        check("lock", {4'h0, lock}, 5'h01);
        for (int i = 0; i < 4; i++) begin
            r = $unsigned($random(seed)) % 510;
            a = {r[8:0], 16'h0000};
            pread(a, 1'b1);
            wr(a + 25'h000_0100, 1'b1);
            cmdp(8'h80, a);
            wr(a, 1'b0);
            cmdp(8'hC0, a);
            wr(a, 1'b1);
        end
        cmdp(8'h80, a);
        hw_reset();
        wr(a, 1'b1);
        $display("test dynamic done");
        for (int p = 0; p < 2; p++) begin
            @(posedge clock);
            placement <= p[0];
            a = p[0] ? 25'h000_1000 : 25'h1FF_1000;
            b = a - 25'h000_1000;
            cmdp(8'h20, a);
            host_u.access(1'b0, b);
            wr(b, 1'b0);
            wait_idle();
            pread(a, 1'b0);
            pread(b, 1'b1);
            wr(a, 1'b0);
            hw_reset();
            pread(a, 1'b0);
            notes.push_back(5'h10);
            host_u.access(1'b0, a);
            r = $random(seed);
            cmdp(8'h10, r[24:0]);
            wait_idle();
            pread(a, 1'b1);
        end
        $display("test persistent done");
        cmdp(8'h04, 25'h000_0000);
        @(negedge clock);
        check("lock", {4'h0, lock}, 5'h00);
        cmdp(8'h20, a);
        @(negedge clock);
        check("fail", {3'h0, busy, ppb_fail}, 5'h01);
        pread(a, 1'b1);
        cmdp(8'h80, b);
        cmdp(8'h02, 25'h000_0000);
        cmdp(8'h01, 25'h000_0000);
        @(negedge clock);
        check("lock", {4'h0, lock}, 5'h00);
        wr(b, 1'b1);
        $display("test lock done");
        @(posedge clock);
        password_mode <= 1'b1;
        hw_reset();
        @(negedge clock);
        check("lock", {4'h0, lock}, 5'h00);
        cmdp(8'h02, 25'h000_0000);
        @(negedge clock);
        check("lock", {4'h0, lock}, 5'h01);
        cmdp(8'h20, a);
        wait_idle();
        check("fail", {3'h0, busy, ppb_fail}, 5'h00);
        pread(a, 1'b0);
        repeat (4) @(posedge clock);
        check("pending", 5'(notes.size()), 5'h00);
        $display("test password done");
        report_and_stop();
    end
endmodule
